// ### ccm_unit.sv
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module ccm_unit #(
  parameter bit IS_UNIT_TWO = 1'b0
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire ccm_pkg::ccm_bus_req_s busReq,
  output logic [ccm_pkg::DATA_W-1:0] rdData,
  input wire logic [ccm_pkg::CNT_W-1:0] timerCount,
  input wire logic capPinIn,
  output logic capPinOut,
  output logic capPinOe,
  input wire logic pwmLevel,
  input wire logic adcEnable,
  output logic timerClear,
  output logic adcStart,
  output logic irq
);
  import ccm_pkg::*;

  // ==========================================================
  // Register decode
  logic wrCtrl;
  logic wrLo;
  logic wrHi;
  logic wrFlag;
  logic wrEnable;
  logic wrPort;
  logic [CTRL_W-1:0] ctrl_q;
  logic [1:0] port_q;
  logic [CNT_W-1:0] valPair_q;
  logic [DATA_W-1:0] rdData_q;
  logic [DATA_W-1:0] rdMux;
  logic [DATA_W-1:0] flagStatus;
  logic [DATA_W-1:0] flagMask;
  logic [DATA_W-1:0] flagSet;
  logic [3:0] mode;

  // Strobes qualified by address; unmapped offsets are ignored
  assign wrCtrl = busReq.wr && busReq.addr == OFF_CTRL;
  assign wrLo = busReq.wr && busReq.addr == OFF_VAL_LO;
  assign wrHi = busReq.wr && busReq.addr == OFF_VAL_HI;
  assign wrFlag = busReq.wr && busReq.addr == OFF_FLAG;
  assign wrEnable = busReq.wr && busReq.addr == OFF_ENABLE;
  assign wrPort = busReq.wr && busReq.addr == OFF_PORT;

  // ==========================================================
  // Mode decode
  logic capMode;
  logic cmpMode;
  logic pwmMode;

  assign mode = ctrl_q[3:0];
  assign capMode = mode[3:2] == GRP_CAP;
  assign cmpMode = mode[3:2] == GRP_CMP;
  assign pwmMode = mode[3:2] == GRP_PWM;

  // Control register; upper two bits always read as zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= CTRL_RST;
    end else if (wrCtrl) begin
      ctrl_q <= busReq.wdata[CTRL_W-1:0];
    end
  end

  // Port latch: data bit and direction bit (one means input)
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      port_q <= PORT_RST;
    end else if (wrPort) begin
      port_q <= busReq.wdata[1:0];
    end
  end

  // ==========================================================
  // Pin path
  logic pinOut_q;
  logic pinDrive;
  logic pinLevel;
  logic cmpLatch_q;

  // Peripheral drives the pin level in compare and PWM modes; the output enable always follows the port direction bit
  assign pinDrive = pwmMode ? pwmLevel :
    cmpMode ? cmpLatch_q : port_q[PORT_DATA_BIT];
  assign capPinOe = ~port_q[PORT_DIR_BIT];
  assign capPinOut = pinOut_q;
  // A driven pin is watched at its own driven level
  assign pinLevel = capPinOe ? pinOut_q : capPinIn;

  // Registered pin level keeps the output glitch free
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pinOut_q <= 1'b0;
    end else begin
      pinOut_q <= pinDrive;
    end
  end

  // ==========================================================
  // Capture path
  logic capEvent;

  ccm_capture_edge u_edge (
    .sys_clk(sys_clk),
    .rst(rst),
    .pinLevel(pinLevel),
    .mode(mode),
    .capEvent(capEvent),
    .prescCount()
  );

  // Capture/compare value pair; a capture beats a software write.
  // No overrun guard: a later event simply overwrites the pair.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      valPair_q <= VAL_RST;
    end else if (capEvent) begin
      valPair_q <= timerCount;
    end else begin
      if (wrLo) begin
        valPair_q[7:0] <= busReq.wdata;
      end
      if (wrHi) begin
        valPair_q[15:8] <= busReq.wdata;
      end
    end
  end

  // ==========================================================
  // Compare path
  logic matchNow;
  logic matchPrev_q;
  logic matchPulse;
  logic trigPulse;
  logic timerClear_q;
  logic adcStart_q;

  // Act once per match, not for every cycle the timer sits there
  assign matchNow = cmpMode && timerCount == valPair_q;
  assign matchPulse = matchNow & ~matchPrev_q;
  assign trigPulse = matchPulse && mode == CMP_TRIG;

  // Compare output latch; forced low while the unit is off
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cmpLatch_q <= 1'b0;
    end else if (mode == MODE_OFF) begin
      cmpLatch_q <= 1'b0;
    end else if (matchPulse && mode == CMP_SET) begin
      cmpLatch_q <= 1'b1;
    end else if (matchPulse && mode == CMP_CLR) begin
      cmpLatch_q <= 1'b0;
    end
  end

  // Match history and trigger pulses to the timer and converter
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      matchPrev_q <= 1'b0;
      timerClear_q <= 1'b0;
      adcStart_q <= 1'b0;
    end else begin
      matchPrev_q <= matchNow;
      timerClear_q <= trigPulse;
      adcStart_q <= trigPulse & IS_UNIT_TWO & adcEnable;
    end
  end

  assign timerClear = timerClear_q;
  assign adcStart = adcStart_q;

  // ==========================================================
  // Event flag and interrupt
  // Every compare mode flags its match; pin action depends on mode
  assign flagSet = FLAG_MASK & {DATA_W{capEvent | matchPulse}};

  ccm_event_flags u_flags (
    .sys_clk(sys_clk),
    .rst(rst),
    .setIn(flagSet),
    .clrWr(wrFlag),
    .maskWr(wrEnable),
    .wrData(busReq.wdata),
    .status(flagStatus),
    .mask(flagMask),
    .irq(irq)
  );

  // ==========================================================
  // Read path: data valid only in the cycle after the strobe
  assign rdMux = busReq.addr == OFF_CTRL ? {2'b00, ctrl_q} :
    busReq.addr == OFF_VAL_LO ? valPair_q[7:0] :
    busReq.addr == OFF_VAL_HI ? valPair_q[15:8] :
    busReq.addr == OFF_FLAG ? flagStatus :
    busReq.addr == OFF_ENABLE ? flagMask :
    busReq.addr == OFF_PORT ? {6'h00, port_q} : 8'h00;

  // Read data register returns to zero when no read is pending
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdData_q <= 8'h00;
    end else begin
      rdData_q <= busReq.rd ? rdMux : 8'h00;
    end
  end

  assign rdData = rdData_q;

  // ==========================================================
  // Checks
  capture_load_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    capEvent |=> valPair_q == $past(timerCount))
    else $error("capture pair did not load the timer count");

  cmp_high_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (matchPulse && mode == CMP_SET) |=> cmpLatch_q ##1 capPinOut)
    else $error("set-on-match did not raise the pin");

  cmp_low_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (matchPulse && mode == CMP_CLR) |=> !cmpLatch_q)
    else $error("clear-on-match did not lower the output");

  swi_pin_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (matchPulse && mode == CMP_SWI) |=> cmpLatch_q == $past(cmpLatch_q))
    else $error("software interrupt mode changed the pin");

  trig_pulse_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    trigPulse |=> timerClear ##1 !timerClear)
    else $error("special trigger did not pulse timer clear");

  off_latch_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (mode == MODE_OFF) |=> !cmpLatch_q)
    else $error("compare latch not forced low when off");

  match_flag_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (matchPulse || capEvent) |=> flagStatus[2])
    else $error("event did not set the unit flag");

  rd_idle_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    !busReq.rd |=> rdData == 8'h00)
    else $error("read data not zero outside a read");

  rd_ctrl_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (busReq.rd && busReq.addr == OFF_CTRL) |=>
    rdData == {2'b00, $past(ctrl_q)})
    else $error("control read did not return the mode field");

  ctrl_load_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    wrCtrl |=> ctrl_q == $past(busReq.wdata[CTRL_W-1:0]))
    else $error("control write did not land");

  val_lo_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (wrLo && !capEvent) |=> valPair_q[7:0] == $past(busReq.wdata))
    else $error("low value byte write did not land");

  val_hi_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (wrHi && !capEvent) |=> valPair_q[15:8] == $past(busReq.wdata))
    else $error("high value byte write did not land");

  pwm_follow_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    pwmMode |=> capPinOut == $past(pwmLevel))
    else $error("pin did not follow the waveform input");

  trig_pin_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (matchPulse && mode == CMP_TRIG) |=> cmpLatch_q == $past(cmpLatch_q))
    else $error("special trigger changed the pin");

  adc_gate_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (trigPulse && !adcEnable) |=> !adcStart)
    else $error("conversion started while converter disabled");

  adc_pair_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    adcStart |-> timerClear)
    else $error("conversion start without timer clear");

  off_quiet_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (mode == MODE_OFF) |-> !(capEvent || matchPulse))
    else $error("event raised while the unit is off");

  cap_only_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    capEvent |-> capMode)
    else $error("capture event outside capture modes");

  port_cap_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (mode == CAP_RISE && capPinOe && $past(capPinOe) &&
    capPinOut && !$past(capPinOut)) |-> capEvent)
    else $error("driven pin edge did not capture");

endmodule

// ### ccm_pkg.sv
package ccm_pkg;

  // ==========================================================
  // Widths
  localparam int DATA_W = 8;
  localparam int ADDR_W = 3;
  localparam int CNT_W = 16;
  localparam int PRESC_W = 4;

  // ==========================================================
  // Register offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL = 3'h0;
  localparam logic [ADDR_W-1:0] OFF_VAL_LO = 3'h1;
  localparam logic [ADDR_W-1:0] OFF_VAL_HI = 3'h2;
  localparam logic [ADDR_W-1:0] OFF_FLAG = 3'h3;
  localparam logic [ADDR_W-1:0] OFF_ENABLE = 3'h4;
  localparam logic [ADDR_W-1:0] OFF_PORT = 3'h5;

  // ==========================================================
  // Field positions and reset values
  localparam int CTRL_W = 6;
  localparam int PORT_DATA_BIT = 0;
  localparam int PORT_DIR_BIT = 1;
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
  localparam logic [1:0] PORT_RST = 2'h2;
  localparam logic [DATA_W-1:0] FLAG_MASK = 8'h04;
  localparam logic [DATA_W-1:0] FLAG_RST = 8'h00;
  localparam logic [CNT_W-1:0] VAL_RST = 16'h0000;
  localparam logic [PRESC_W-1:0] PRESC_RST = 4'h0;
  localparam logic [PRESC_W-1:0] PRESC_LAST16 = 4'hF;
  localparam logic [1:0] PRESC_LAST4 = 2'h3;

  // ==========================================================
  // Mode field encodings
  typedef enum logic [3:0] {
    MODE_OFF = 4'h0,
    CAP_FALL = 4'h4,
    CAP_RISE = 4'h5,
    CAP_4TH = 4'h6,
    CAP_16TH = 4'h7,
    CMP_SET = 4'h8,
    CMP_CLR = 4'h9,
    CMP_SWI = 4'hA,
    CMP_TRIG = 4'hB
  } ccm_mode_e;
  localparam logic [1:0] GRP_CAP = 2'h1;
  localparam logic [1:0] GRP_CMP = 2'h2;
  localparam logic [1:0] GRP_PWM = 2'h3;

  // ==========================================================
  // Register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } ccm_bus_req_s;

endpackage

// ### ccm_capture_edge.sv
`timescale 1ns/1ps
module ccm_capture_edge (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic pinLevel,
  input wire logic [3:0] mode,
  output logic capEvent,
  output logic [ccm_pkg::PRESC_W-1:0] prescCount
);
  import ccm_pkg::*;

  logic prevPin_q;
  logic [PRESC_W-1:0] presc_q;
  logic [PRESC_W-1:0] presc_d;
  logic capMode;
  logic rise;
  logic fall;
  logic hit4;
  logic hit16;

  // ==========================================================
  // Edge detection and event select
  assign capMode = mode[3:2] == GRP_CAP;
  assign rise = pinLevel & ~prevPin_q;
  assign fall = ~pinLevel & prevPin_q;
  assign hit4 = rise && presc_q[1:0] == PRESC_LAST4;
  assign hit16 = rise && presc_q == PRESC_LAST16;
  assign capEvent = capMode & (
    (mode == CAP_FALL & fall) | (mode == CAP_RISE & rise) |
    (mode == CAP_4TH & hit4) |
    (mode == CAP_16TH & hit16));
  // Counter keeps running across prescaler swaps on purpose
  assign presc_d = !capMode ? PRESC_RST :
    rise ? PRESC_W'(presc_q + 1'b1) : presc_q;
  assign prescCount = presc_q;

  // Previous pin level and prescaler; the pin history runs in every
  // mode, so a mode change finds no stale edge to report
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prevPin_q <= 1'b0;
      presc_q <= PRESC_RST;
    end else begin
      prevPin_q <= pinLevel;
      presc_q <= presc_d;
    end
  end

  fall_capture_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (mode == CAP_FALL && !pinLevel && $past(pinLevel)) |-> capEvent)
    else $error("falling edge missed in falling capture mode");

  sixteenth_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (mode == CAP_16TH && capEvent) |-> (presc_q == 4'hF && rise))
    else $error("sixteenth edge capture at wrong count");

  presc_clear_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (mode[3:2] != 2'h1) |=> (presc_q == 4'h0))
    else $error("prescaler not cleared outside capture");

endmodule

// ### ccm_event_flags.sv
`timescale 1ns/1ps
module ccm_event_flags (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [ccm_pkg::DATA_W-1:0] setIn,
  input wire logic clrWr,
  input wire logic maskWr,
  input wire logic [ccm_pkg::DATA_W-1:0] wrData,
  output logic [ccm_pkg::DATA_W-1:0] status,
  output logic [ccm_pkg::DATA_W-1:0] mask,
  output logic irq
);
  import ccm_pkg::*;

  logic [DATA_W-1:0] stat_q;
  logic [DATA_W-1:0] mask_q;

  // ==========================================================
  // Sticky flags, write one to clear; a set in the same cycle wins
  for (genvar i = 0; i < DATA_W; i++) begin : g_flag
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        stat_q[i] <= FLAG_RST[i];
        mask_q[i] <= 1'b0;
      end else begin
        if (FLAG_MASK[i] && setIn[i]) begin
          stat_q[i] <= 1'b1;
        end else if (clrWr && wrData[i]) begin
          stat_q[i] <= 1'b0;
        end
        if (maskWr) begin
          mask_q[i] <= wrData[i] & FLAG_MASK[i];
        end
      end
    end
  end

  // Level interrupt while any enabled flag stands
  assign irq = |(stat_q & mask_q);
  assign status = stat_q;
  assign mask = mask_q;

  flag_sticky_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (setIn[2] || (stat_q[2] && !(clrWr && wrData[2]))) |=> stat_q[2])
    else $error("event flag lost or cleared by hardware");

  irq_level_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (stat_q[2] && mask_q[2]) |-> irq)
    else $error("interrupt low with enabled flag set");

endmodule

// ### ccm_pin_src.sv
`timescale 1ns/1ps
// ==========================================================
// Event source on the capture pin
module ccm_pin_src (
  input wire logic sys_clk,
  output logic pinOut
);
  initial pinOut = 1'b0;

  // Level changes only just after an edge, so the unit sees a clean sample
  task automatic drive(input logic v, input int gap);
    @(posedge sys_clk);
    pinOut <= v;
    repeat (gap) @(posedge sys_clk);
  endtask

  // Short gap is a fast source, a long gap a slow one
  task automatic pulses(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      drive(1'b1, gap);
      drive(1'b0, gap);
    end
  endtask
endmodule

// ### test_capture_compare_mode_unit.sv
`timescale 1ns/1ps
module test_capture_compare_mode_unit;
  import ccm_pkg::*;
  logic sys_clk, rst, capPin, pwmLevel, adcEnable;
  logic capPinOut, capPinOe, timerClear, adcStart, irq;
  ccm_bus_req_s busReq;
  logic [DATA_W-1:0] rdData;
  logic [CNT_W-1:0] timerCount;
  int mismatches = 0;
  int compares = 0;
  int clrSeen = 0;
  int adcSeen = 0;
  ccm_mode_e pm[2] = '{CAP_4TH, CAP_16TH};
  int pn[2] = '{4, 16};
  logic [7:0] rstTab[8] = '{8'(CTRL_RST), 8'h00, 8'h00, FLAG_RST, 8'h00,
                            8'(PORT_RST), 8'h00, 8'h00};

  // ==========================================================
  // Unit under test and pin source
  ccm_unit #(.IS_UNIT_TWO(1'b1)) uut (.sys_clk(sys_clk), .rst(rst),
    .busReq(busReq), .rdData(rdData), .timerCount(timerCount),
    .capPinIn(capPin), .capPinOut(capPinOut), .capPinOe(capPinOe),
    .pwmLevel(pwmLevel), .adcEnable(adcEnable), .timerClear(timerClear),
    .adcStart(adcStart), .irq(irq));
  ccm_pin_src src (.sys_clk(sys_clk), .pinOut(capPin));

  // Clock, 100 ns period
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // Count trigger pulses; each is one cycle, so a count shows a stuck pulse
  always @(posedge sys_clk) begin
    if (timerClear === 1'b1) clrSeen++;
    if (adcStart === 1'b1) adcSeen++;
  end

  // ==========================================================
  // Bus and check tasks
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    busReq <= '0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rc(input string nm, input logic [ADDR_W-1:0] a,
                    input logic [7:0] e);
    @(posedge sys_clk);
    busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    busReq <= '0;
    #1;
    chk(nm, rdData, e);
  endtask

  // Off first, then the new mode, then drop any stale flag
  task automatic setMode(input logic [3:0] m);
    wr(OFF_CTRL, 8'h00);
    wr(OFF_CTRL, {4'h0, m});
    wr(OFF_FLAG, FLAG_MASK);
  endtask

  // Timer changes on the clock edge like a synchronous counter
  task automatic setT(input logic [15:0] v);
    @(posedge sys_clk);
    timerCount <= v;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Mismatch first so the compare re-arms
  task automatic cmpStep(input logic [3:0] m, input logic pin);
    wr(OFF_CTRL, {4'h0, m});
    wr(OFF_FLAG, FLAG_MASK);
    setT(16'h0000);
    setT(16'h0050);
    settle(4);
    chk("cmpPin", capPinOut, pin);
    rc("cmpFlag", OFF_FLAG, FLAG_MASK);
  endtask

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    print_verdict();
  end

  // ==========================================================
  // Test sequence
  initial begin
    rst = 1'b1;
    busReq = '0;
    timerCount = '0;
    pwmLevel = 1'b0;
    adcEnable = 1'b1;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    for (int a = 0; a < 8; a++) rc("reset", 3'(a), rstTab[a]);
    chk("resetOe", capPinOe, 0);
    chk("resetIrq", irq, 0);
    wr(OFF_CTRL, 8'hFF);
    rc("ctrlBits", OFF_CTRL, 8'h3F);
    wr(3'h6, 8'hFF);
    rc("unmapped", 3'h6, 8'h00);
    $display("test reset done");

    // Rising capture, mask, overwrite, clear; pin left as input
    setMode(CAP_RISE);
    setT(16'h1234);
    src.pulses(1, 3);
    rc("flag", OFF_FLAG, FLAG_MASK);
    chk("irqMasked", irq, 0);
    wr(OFF_ENABLE, FLAG_MASK);
    #1 chk("irq", irq, 1);
    rc("lo", OFF_VAL_LO, 8'h34);
    rc("hi", OFF_VAL_HI, 8'h12);
    setT(16'hABCD);
    src.pulses(1, 3);
    rc("lo2", OFF_VAL_LO, 8'hCD);
    rc("hi2", OFF_VAL_HI, 8'hAB);
    wr(OFF_FLAG, FLAG_MASK);
    #1 chk("irqClr", irq, 0);
    $display("test rising done");

    setMode(CAP_FALL);
    setT(16'h0111);
    src.drive(1'b1, 3);
    rc("noRise", OFF_FLAG, 8'h00);
    src.drive(1'b0, 3);
    rc("fall", OFF_FLAG, FLAG_MASK);
    rc("fallLo", OFF_VAL_LO, 8'h11);
    $display("test falling done");

    // Prescaled capture fires on the last edge of each group only
    foreach (pm[i]) begin
      setMode(pm[i]);
      setT(16'(pn[i]));
      src.pulses(pn[i] - 1, 1);
      rc("preEarly", OFF_FLAG, 8'h00);
      src.pulses(1, 1);
      rc("preFire", OFF_FLAG, FLAG_MASK);
      rc("preLo", OFF_VAL_LO, 8'(pn[i]));
    end
    setT(16'h0077);
    setMode(CAP_4TH);
    src.pulses(2, 1);
    wr(OFF_CTRL, {4'h0, CMP_SWI});
    wr(OFF_CTRL, {4'h0, CAP_4TH});
    wr(OFF_FLAG, FLAG_MASK);
    src.pulses(3, 1);
    rc("preCleared", OFF_FLAG, 8'h00);
    src.pulses(1, 1);
    rc("preAfterClr", OFF_FLAG, FLAG_MASK);
    setMode(CAP_4TH);
    src.pulses(2, 1);
    wr(OFF_CTRL, {4'h0, CAP_16TH});
    wr(OFF_FLAG, FLAG_MASK);
    src.pulses(13, 1);
    rc("preKept", OFF_FLAG, 8'h00);
    src.pulses(1, 1);
    rc("preKeptFire", OFF_FLAG, FLAG_MASK);
    $display("test prescaler done");

    // Pin as output: a port latch write is a capture source
    setMode(CAP_RISE);
    wr(OFF_PORT, 8'h00);
    wr(OFF_PORT, 8'h01);
    settle(3);
    chk("portOe", capPinOe, 1);
    chk("portPin", capPinOut, 1);
    rc("portCap", OFF_FLAG, FLAG_MASK);
    $display("test port done");

    // Timer parked off the old capture value so no match comes early
    setT(16'h0000);
    setMode(CMP_SET);
    wr(OFF_VAL_LO, 8'h50);
    wr(OFF_VAL_HI, 8'h00);
    cmpStep(CMP_SET, 1'b1);
    cmpStep(CMP_SWI, 1'b1);
    cmpStep(CMP_TRIG, 1'b1);
    chk("clrOne", 16'(clrSeen), 16'h0001);
    chk("adcOne", 16'(adcSeen), 16'h0001);
    @(posedge sys_clk);
    adcEnable <= 1'b0;
    cmpStep(CMP_TRIG, 1'b1);
    chk("clrTwo", 16'(clrSeen), 16'h0002);
    chk("adcOff", 16'(adcSeen), 16'h0001);
    cmpStep(CMP_CLR, 1'b0);
    cmpStep(CMP_SWI, 1'b0);
    // Raise the latch, then turning the unit off must drop it
    cmpStep(CMP_SET, 1'b1);
    wr(OFF_CTRL, 8'h00);
    cmpStep(CMP_SWI, 1'b0);
    $display("test compare done");

    // Both ends of the 11xx range follow the waveform input
    foreach (pn[k]) begin
      wr(OFF_CTRL, k == 0 ? 8'h0C : 8'h0F);
      for (int v = 1; v >= 0; v--) begin
        @(posedge sys_clk);
        pwmLevel <= 1'(v);
        settle(3);
        chk("pwm", capPinOut, 16'(v));
      end
    end
    $display("test pwm done");
    print_verdict();
  end
endmodule
